// ---- hdl/prom_bus_pkg.sv ----
// Package with constants and carriers for the read-only memory board slave
package prom_bus_pkg;
   // ==========================================
   // Address field layout
   localparam int ADDR_W = 16;
   localparam int BYTE_LSB = 0;
   localparam int BYTE_W = 8;
   localparam int SOCK_LSB = 8;
   localparam int SOCK_W = 4;
   localparam int BLOCK_LSB = 12;
   localparam int BLOCK_W = 4;
   localparam int SOCKETS = 16;
   localparam int DATA_W = 8;
   localparam int BANK_SIZE = SOCKETS / 2;
   localparam int POS_W = SOCK_W - 1;
   localparam int BANK_BIT = SOCK_W - 1;
   // ==========================================
   // Read delay timing
   localparam int CLK_MHZ = 100;
   localparam int DELAY_BASE_NS = 1000;
   localparam int DELAY_STEP_NS = 500;
   localparam int NS_PER_US = 1000;
   localparam int DELAY_SEL_W = 2;
   localparam int CNT_W = 9;
   localparam int SYNC_W = BLOCK_W + DELAY_SEL_W;
   // ==========================================
   // Reset values
   localparam logic [SOCKETS-1:0] SOCK_OFF_N = 16'hFFFF;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 9'h000;
   localparam logic [SYNC_W-1:0] SYNC_RST = 6'h00;
   // ==========================================
   // Carriers
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic mem_read;
   } bus_req_t;
   typedef struct packed {
      logic [BLOCK_W-1:0] board_base;
      logic [DELAY_SEL_W-1:0] delay_sel;
   } strap_t;
   // Access phase
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DONE = 2'b10
   } phase_t;
endpackage : prom_bus_pkg

// ---- hdl/prom_board_bus_slave.sv ----
// Read-only memory board slave: decode, read delay and bus drivers
//
// Contract
// RULE_01 - Low eight address bits go unchanged to every memory socket.
// RULE_02 - Address bits 8 to 11 enable exactly one of sixteen sockets.
// RULE_03 - Address bits 12 to 15 compare against the four-bit board base.
// RULE_04 - Board enabled only on block match with memory-read status high.
// RULE_05 - Ready line held low from the delay stage until the delay ends.
// RULE_06 - Delay length is a static strap selection for fast or slow chips.
// RULE_07 - Delay stage cleared when the board enable goes inactive.
// RULE_08 - Socket data reaches the data-in bus only while board is enabled.
// RULE_09 - Each socket gives 256 bytes and answers at its own address.
// RULE_10 - Board base selects any of sixteen 4K blocks in 64K space.
// RULE_11 - Bus outputs stay released whenever the board is not enabled.
// RULE_12 - Delay choices are two to five machine cycles, 1000 to 2500 ns.
// RULE_13 - Bit 11 low picks low bank, high picks high bank; bits 10-8 position.
// RULE_14 - Memory writes are ignored: no drivers, no ready change.
`timescale 1ns/1ps
module prom_board_bus_slave
   import prom_bus_pkg::*;
#(
   parameter int CLOCK_MHZ = CLK_MHZ,
   parameter int BASE_DELAY_NS = DELAY_BASE_NS,
   parameter int STEP_DELAY_NS = DELAY_STEP_NS
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire bus_req_t bus_req,
   input wire strap_t straps,
   input wire logic [DATA_W-1:0] prom_data,
   output logic [BYTE_W-1:0] prom_byte_addr,
   output logic [SOCKETS-1:0] socket_enable_n,
   output logic [DATA_W-1:0] data_in_out,
   output logic data_in_oe,
   output logic ready_out,
   output logic ready_oe,
   output logic board_select_active
);

   // ==========================================
   // Helper functions

   // Wait cycles for a strap code, one machine cycle per step
   function automatic logic [CNT_W-1:0] delay_cycles(input logic [DELAY_SEL_W-1:0] sel);
      int ns;
      ns = BASE_DELAY_NS + STEP_DELAY_NS * int'(sel); // see RULE_12
      return CNT_W'(ns * CLOCK_MHZ / NS_PER_US);
   endfunction : delay_cycles

   // ==========================================
   // Strap synchronisers

   logic [SYNC_W-1:0] sync1_ff;
   logic [SYNC_W-1:0] sync2_ff;
   logic [SYNC_W-1:0] sync3_ff;
   logic [SYNC_W-1:0] strap_ff;
   logic [SYNC_W-1:0] nxt_strap;
   wire [SYNC_W-1:0] strap_raw = straps;

   // First stage catches the asynchronous jumper levels
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync1_ff <= SYNC_RST;
      end else begin
         sync1_ff <= strap_raw;
      end
   end

   // Second stage, the only reader of the first
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync2_ff <= SYNC_RST;
      end else begin
         sync2_ff <= sync1_ff;
      end
   end

   // Third stage, compared against the second
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync3_ff <= SYNC_RST;
      end else begin
         sync3_ff <= sync2_ff;
      end
   end

   // Accepted strap value, moves only on agreement
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         strap_ff <= SYNC_RST;
      end else begin
         strap_ff <= nxt_strap;
      end
   end

   // Accept a bit once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_agree
         assign nxt_strap[gi] = (sync2_ff[gi] == sync3_ff[gi]) ? sync3_ff[gi] : strap_ff[gi];
      end
   endgenerate

   strap_t strap_now;
   assign strap_now = strap_ff; // see RULE_06

   // ==========================================
   // Address decode

   wire [BLOCK_W-1:0] addr_block = bus_req.addr[BLOCK_LSB +: BLOCK_W];
   wire [SOCK_W-1:0] addr_sock = bus_req.addr[SOCK_LSB +: SOCK_W];
   wire [BYTE_W-1:0] addr_byte = bus_req.addr[BYTE_LSB +: BYTE_W];
   // Any of sixteen 4K blocks may be chosen
   wire block_hit = (addr_block == strap_now.board_base); // see RULE_03 see RULE_10
   // Writes never qualify the board
   wire enable_now = block_hit && bus_req.mem_read; // see RULE_04 see RULE_14

   // ==========================================
   // Socket decode, two banks of eight

   wire bank_high = addr_sock[BANK_BIT]; // see RULE_13
   wire [POS_W-1:0] bank_pos = addr_sock[POS_W-1:0];
   logic [BANK_SIZE-1:0] low_bank_hot;
   logic [BANK_SIZE-1:0] high_bank_hot;
   logic [SOCKETS-1:0] sock_hot;

   // One decoder per bank, each gated by the bank bit
   genvar gb;
   generate
      for (gb = 0; gb < BANK_SIZE; gb++) begin : g_bank
         assign low_bank_hot[gb] = !bank_high && (bank_pos == POS_W'(gb));
         assign high_bank_hot[gb] = bank_high && (bank_pos == POS_W'(gb));
      end
   endgenerate

   // Low bank fills sockets 0-7, high bank 8-15
   assign sock_hot = {high_bank_hot, low_bank_hot}; // see RULE_02 see RULE_09

   // ==========================================
   // Read delay stage

   phase_t phase_ff;
   phase_t nxt_phase;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic enable_ff;
   logic [CNT_W-1:0] target_ff;
   wire [CNT_W-1:0] cnt_target = delay_cycles(strap_now.delay_sel);
   // Length taken while idle, held through the access
   wire [CNT_W-1:0] nxt_target = (phase_ff == ST_IDLE) ? cnt_target : target_ff;
   wire cnt_last = (cnt_ff >= target_ff - CNT_W'(1));
   // Enable dropping restarts the next access from zero
   wire enable_drop = enable_ff && !enable_now; // see RULE_07

   // Phase and counter next state
   always_comb begin
      nxt_phase = phase_ff;
      nxt_cnt = cnt_ff;
      case (phase_ff)
         ST_IDLE: begin
            nxt_cnt = CNT_RST;
            if (enable_now) begin
               nxt_phase = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!enable_now) begin
               nxt_phase = ST_IDLE;
               nxt_cnt = CNT_RST; // see RULE_07
            end else if (cnt_last) begin
               nxt_phase = ST_DONE;
            end else begin
               nxt_cnt = cnt_ff + CNT_W'(1);
            end
         end
         ST_DONE: begin
            if (!enable_now) begin
               nxt_phase = ST_IDLE;
               nxt_cnt = CNT_RST;
            end
         end
         default: begin
            nxt_phase = ST_IDLE;
            nxt_cnt = CNT_RST;
         end
      endcase
   end

   // Access phase register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         phase_ff <= ST_IDLE;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // Wait counter, cleared whenever the board drops
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt_ff <= CNT_RST;
      end else begin
         cnt_ff <= nxt_cnt; // see RULE_07
      end
   end

   // Delay length, so a strap move cannot cut a wait short
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         target_ff <= CNT_RST;
      end else begin
         target_ff <= nxt_target; // see RULE_06
      end
   end

   // Previous enable, for the drop detector
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         enable_ff <= 1'b0;
      end else begin
         enable_ff <= enable_now;
      end
   end

   // ==========================================
   // Output registers

   wire active_next = enable_now && !enable_drop;
   // Ready stays low until the wait completes
   wire ready_next = (nxt_phase == ST_DONE); // see RULE_05
   wire [DATA_W-1:0] data_next = active_next ? prom_data : DATA_RST; // see RULE_08
   logic [SOCKETS-1:0] sock_next_n;

   // Per-socket enable, low only for the decoded socket of an enabled read
   genvar gs;
   generate
      for (gs = 0; gs < SOCKETS; gs++) begin : g_sock
         assign sock_next_n[gs] = !(active_next && sock_hot[gs]); // see RULE_02
      end
   endgenerate

   // Byte address to every socket, never gated
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prom_byte_addr <= BYTE_RST;
      end else begin
         prom_byte_addr <= addr_byte; // see RULE_01
      end
   end

   // Socket enables, all high when the board is idle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         socket_enable_n <= SOCK_OFF_N;
      end else begin
         socket_enable_n <= sock_next_n;
      end
   end

   // Data-in bus value, cleared when not driving
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         data_in_out <= DATA_RST;
      end else begin
         data_in_out <= data_next;
      end
   end

   // Data-in driver enable, released when not enabled
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         data_in_oe <= 1'b0;
      end else begin
         data_in_oe <= active_next; // see RULE_08 see RULE_11
      end
   end

   // Ready level, low until the delay ends
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ready_out <= 1'b0;
      end else begin
         ready_out <= ready_next; // see RULE_05
      end
   end

   // Ready driver enable, only during an enabled read
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ready_oe <= 1'b0;
      end else begin
         ready_oe <= active_next; // see RULE_05 see RULE_11
      end
   end

   // Board enable as seen at the pins
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         board_select_active <= 1'b0;
      end else begin
         board_select_active <= active_next; // see RULE_04
      end
   end

endmodule : prom_board_bus_slave

// ---- verif/prom_board_bus_slave_sva.sv ----
// Port checks for the memory board slave
`timescale 1ns/1ps
module prom_board_bus_slave_sva
   import prom_bus_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire bus_req_t bus_req,
   input wire strap_t straps,
   input wire logic [7:0] prom_data,
   input wire logic [7:0] prom_byte_addr,
   input wire logic [15:0] socket_enable_n,
   input wire logic [7:0] data_in_out,
   input wire logic data_in_oe,
   input wire logic ready_out,
   input wire logic ready_oe,
   input wire logic board_select_active
);
   int sel_cnt_ff;
   int nxt_sel_cnt;
   int delay_n;
   // =====
   // Cycles selected, and delay due
   assign nxt_sel_cnt = board_select_active ? sel_cnt_ff + 1 : 0;
   assign delay_n = 100 + 50 * straps.delay_sel;
   always_ff @(posedge clock) sel_cnt_ff <= rst_n ? nxt_sel_cnt : 0;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   chk_byte_route: assert property (
      board_select_active |-> prom_byte_addr == $past(bus_req.addr[7:0])) else $error("byte addr");
   chk_one_socket: assert property (
      board_select_active |-> socket_enable_n == ~(16'h0001 << $past(bus_req.addr[11:8]))) else $error("socket");
   chk_bus_idle: assert property (
      !board_select_active |-> socket_enable_n == SOCK_OFF_N && !data_in_oe && !ready_oe) else $error("idle");
   chk_select_cause: assert property (
      board_select_active == $past(bus_req.mem_read && bus_req.addr[15:12] == straps.board_base)) else $error("sel");
   chk_drive_on: assert property (
      board_select_active |-> data_in_oe && ready_oe) else $error("drive");
   chk_data_lag: assert property (
      data_in_oe && $past(data_in_oe) |-> data_in_out == $past(prom_data)) else $error("data");
   chk_ready_early: assert property (
      ready_out |-> sel_cnt_ff >= delay_n - 3) else $error("ready early");
   chk_ready_late: assert property (
      sel_cnt_ff == delay_n + 3 |-> ready_out) else $error("ready late");
   chk_fresh_count: assert property (
      $rose(board_select_active) |-> !ready_out) else $error("stale");
   cover property (ready_out && straps.delay_sel == 2'h3);
   cover property ($fell(board_select_active));
   cover property (!bus_req.mem_read ##1 !board_select_active);
endmodule : prom_board_bus_slave_sva
bind prom_board_bus_slave prom_board_bus_slave_sva u_prom_board_bus_slave_sva (.*);

// ---- verif/prom_socket_model.sv ----
// Socket array model
`timescale 1ns/1ps
module prom_socket_model
   import prom_bus_pkg::*;
(
   input wire logic [7:0] prom_byte_addr,
   input wire logic [15:0] socket_enable_n,
   output logic [7:0] prom_data
);
   logic [7:0] last_val = 8'h00;
   // Byte xor index twice; idle lines flip
   always @* begin
      prom_data = ~last_val;
      for (int i = 0; i < 16; i++) begin
         if (!socket_enable_n[i]) prom_data = prom_byte_addr ^ 8'(i * 17);
      end
   end
   always @(prom_data) if (socket_enable_n != SOCK_OFF_N) last_val = prom_data;
endmodule : prom_socket_model

// ---- verif/tb.sv ----
// Bench for the memory board slave
`timescale 1ns/1ps
module tb;
   import prom_bus_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   bus_req_t bus_req = '0;
   strap_t straps = '0;
   logic [7:0] prom_data, prom_byte_addr, data_in_out;
   logic [15:0] socket_enable_n;
   logic data_in_oe, ready_out, ready_oe, board_select_active;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   prom_board_bus_slave u_prom_board_bus_slave (.*);
   prom_socket_model u_prom_socket_model (.*);
   // =====
   // Clock and hang guard
   initial forever #5 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         close_out();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   // One read or write, held until ready or until the n + 9 cycle limit
   task automatic access(input logic [3:0] base, input logic [1:0] sel, input logic [15:0] a, input logic rd);
      int n;
      int w;
      logic hit;
      n = 100 + 50 * sel;
      hit = rd && a[15:12] == base;
      straps = '{base, sel};
      repeat (5) @(negedge clock);
      bus_req = '{a, rd};
      for (w = 0; w < n + 9 && ready_out !== 1'b1; w++) begin
         @(negedge clock);
         if (w == 1) chk("sock", hit ? ~(16'h0001 << a[11:8]) : 16'hFFFF, socket_enable_n);
         if (w == 1) chk("oe", {3{hit}}, {data_in_oe, ready_oe, board_select_active});
      end
      if (hit) chk("wait", 16'h0001, 16'(w >= n && w <= n + 4));
      repeat (4) @(negedge clock);
      if (hit) chk("hold", 16'h0001, {15'h0000, ready_out});
      if (hit) chk("data", {a[11:8], a[11:8]} ^ a[7:0], data_in_out);
      if (!hit) chk("quiet", 16'h0000, {ready_out, ready_oe, data_in_oe});
      bus_req.mem_read = 1'b0;
      repeat (2) @(negedge clock);
      chk("rel", 16'hFFF8, {socket_enable_n[15:3], ready_out, ready_oe, data_in_oe});
   endtask : access
   // Every socket in turn
   task automatic t_sockets();
      for (int i = 0; i < 16; i++) access(4'h3, 2'h0, {4'h3, 4'(i), 8'(255 - i * 13)}, 1'b1);
      $display("sockets done");
   endtask : t_sockets
   // Each delay code on its own block
   task automatic t_delays();
      for (int s = 0; s < 4; s++) access(4'(s * 5), 2'(s), {4'(s * 5), 12'hA5C}, 1'b1);
      $display("delays done");
   endtask : t_delays
   // A write and a block miss
   task automatic t_refuse();
      access(4'h7, 2'h1, 16'h7123, 1'b0);
      access(4'h7, 2'h1, 16'h8123, 1'b1);
      $display("refusals done");
   endtask : t_refuse
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   // Reset, then scenarios
   initial begin
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      t_sockets();
      t_delays();
      t_refuse();
      close_out();
   end
endmodule : tb
